/* rtl/plc_core.sv */
// Purpose: Reference and feedback dividers, phase comparator masks, window lock detector
// Assumes: ref_in and osc_in are synchronous levels; rising edges count
// Notes: Windows are resolved to whole clk_sys cycles, never below one
//
// The placing of the registers and the APB register port were chosen for this implementation.
module plc_core (
    // System
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Comparator inputs
    input  wire logic        ref_in,
    input  wire logic        osc_in,
    // Pump controls
    output logic             pump_up,
    output logic             pump_down,
    output logic             pump_hiz,
    // Shared pin
    input  wire logic        serial_read_active,
    input  wire logic        serial_data,
    output logic             lock_or_serial_out_pin,
    // Divided edges and flag
    output logic             ref_div_edge,
    output logic             osc_div_edge,
    output logic             lock_indicator
);
    import plc_pkg::*;

    typedef struct packed {
        logic        ref_q;
        logic        osc_q;
        logic [13:0] rcnt;
        logic [18:0] ncnt;
        logic [23:0] acc;
        logic        carry;
        logic [13:0] rdiv;
        logic [18:0] nint;
        logic [23:0] nfrac;
        logic        frac_en;
        logic        up_allow;
        logic        dn_allow;
        logic        push_hi;
        logic        push_lo;
        logic        ld_en;
        logic        win_sel;
        logic [2:0]  tdiv;
        logic [1:0]  tspd;
        logic [2:0]  tgt;
        logic [4:0]  osel;
        logic        share;
        logic        cmp_up;
        logic        cmp_dn;
        logic        win_open;
        logic        first_ref;
        logic [4:0]  win_cnt;
        logic [11:0] hits;
        logic        lock;
        logic        ref_e;
        logic        osc_e;
        logic [31:0] prdata;
    } plc_state_t;

    plc_state_t s_r;
    plc_state_t s_nxt;

    // Window length in cycles, longest time rounded down, at least one
    function automatic logic [4:0] win_cycles(input logic sel, input logic [1:0] spd, input logic [2:0] dv);
        int ns10;
        int cyc;
        ns10 = sel ? int'(WIN_NS10[{spd, dv}]) : ANALOG_WIN_NS10;
        cyc  = ns10 / (CLK_PERIOD_NS * 10);
        if (cyc < 1) begin
            cyc = 1;
        end
        return cyc[4:0];
    endfunction

    // Feedback ratio within the mode's legal range
    function automatic logic [18:0] fb_ratio(input logic fr, input logic [18:0] n, input logic c);
        logic [18:0] b;
        b = n;
        if (fr) begin
            if (b < NFRAC_MIN) begin
                b = NFRAC_MIN;
            end
            if (b > NFRAC_MAX) begin
                b = NFRAC_MAX;
            end
            b = b + {18'h0_0000, c};
        end else if (b < NINT_MIN) begin
            b = NINT_MIN;
        end
        return b;
    endfunction

    function automatic logic [11:0] hit_target(input logic [2:0] code);
        return HIT_BASE << code;
    endfunction

    logic        setup;
    logic        access;
    logic        mapped;
    logic [7:0]  idx;
    logic [4:0]  wlen;
    logic [18:0] ratio;
    logic [13:0] rlim;
    logic        partner;
    logic        hit;
    logic        miss;
    logic [24:0] acc_sum;

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign idx     = paddr[9:2];
    assign mapped  = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h00_0000) &&
                     (idx == IDX_RDIV || idx == IDX_NINT || idx == IDX_NFRAC || idx == IDX_MODE ||
                      idx == IDX_LOCK || idx == IDX_PHASE || idx == IDX_PIN || idx == IDX_STATUS);
    assign wlen    = win_cycles(s_r.win_sel, s_r.tspd, s_r.tdiv);
    assign ratio   = fb_ratio(s_r.frac_en, s_r.nint, s_r.carry);
    assign rlim    = (s_r.rdiv == 14'h0000) ? RDIV_RST : s_r.rdiv;
    assign acc_sum = {1'b0, s_r.acc} + {1'b0, s_r.nfrac};
    assign partner = s_r.first_ref ? s_r.osc_e : s_r.ref_e;
    assign hit     = s_r.ld_en && ((s_r.win_open && partner && s_r.win_cnt < wlen) ||
                                   (!s_r.win_open && s_r.ref_e && s_r.osc_e));
    assign miss    = s_r.ld_en && s_r.win_open && !hit && s_r.win_cnt >= wlen;

    always_comb begin
        s_nxt       = s_r;
        s_nxt.ref_q = ref_in;
        s_nxt.osc_q = osc_in;
        s_nxt.ref_e = 1'b0;
        s_nxt.osc_e = 1'b0;
        // Reference divider
        if (ref_in && !s_r.ref_q) begin
            if (s_r.rcnt + 14'h0001 >= rlim) begin
                s_nxt.rcnt  = 14'h0000;
                s_nxt.ref_e = 1'b1;
            end else begin
                s_nxt.rcnt = s_r.rcnt + 14'h0001;
            end
        end
        // Feedback divider, carry adds one for fractional average
        if (osc_in && !s_r.osc_q) begin
            if ({5'h00, s_r.ncnt} + 24'h00_0001 >= {5'h00, ratio}) begin
                s_nxt.ncnt  = 19'h0_0000;
                s_nxt.osc_e = 1'b1;
                s_nxt.acc   = s_r.frac_en ? acc_sum[23:0] : 24'h00_0000;
                s_nxt.carry = s_r.frac_en && acc_sum[24];
            end else begin
                s_nxt.ncnt = s_r.ncnt + 19'h0_0001;
            end
        end
        // Phase comparator state
        if (s_r.ref_e && s_r.osc_e) begin
            s_nxt.cmp_up = 1'b0;
            s_nxt.cmp_dn = 1'b0;
        end else if (s_r.ref_e) begin
            s_nxt.cmp_up = !s_r.cmp_dn;
            s_nxt.cmp_dn = 1'b0;
        end else if (s_r.osc_e) begin
            s_nxt.cmp_dn = !s_r.cmp_up;
            s_nxt.cmp_up = 1'b0;
        end
        // Lock window
        if (!s_r.ld_en) begin
            s_nxt.win_open = 1'b0;
            s_nxt.win_cnt  = 5'h00;
            s_nxt.hits     = 12'h000;
            s_nxt.lock     = 1'b0;
        end else begin
            if (hit || miss) begin
                s_nxt.win_open = 1'b0;
                s_nxt.win_cnt  = 5'h00;
            end else if (s_r.win_open) begin
                s_nxt.win_cnt = s_r.win_cnt + 5'h01;
            end else if (s_r.ref_e || s_r.osc_e) begin
                s_nxt.win_open  = 1'b1;
                s_nxt.first_ref = s_r.ref_e;
                s_nxt.win_cnt   = 5'h01;
            end
            if (miss) begin
                s_nxt.hits = 12'h000;
                s_nxt.lock = 1'b0;
            end else if (hit) begin
                if (s_r.hits + 12'h001 >= hit_target(s_r.tgt)) begin
                    s_nxt.hits = hit_target(s_r.tgt);
                    s_nxt.lock = 1'b1;
                end else begin
                    s_nxt.hits = s_r.hits + 12'h001;
                end
            end
        end
        // Register writes
        if (access && pwrite && mapped) begin
            unique case (idx)
                IDX_RDIV:  s_nxt.rdiv  = pwdata[13:0];
                IDX_NINT:  s_nxt.nint  = pwdata[18:0];
                IDX_NFRAC: s_nxt.nfrac = pwdata[23:0];
                IDX_MODE:  s_nxt.frac_en = pwdata[F_FRAC_EN];
                IDX_LOCK: begin
                    s_nxt.tgt     = pwdata[F_TGT_LO +: 3];
                    s_nxt.ld_en   = pwdata[F_LD_EN];
                    s_nxt.win_sel = pwdata[F_WIN_SEL];
                    s_nxt.tdiv    = pwdata[F_TDIV_LO +: 3];
                    s_nxt.tspd    = pwdata[F_TSPD_LO +: 2];
                end
                IDX_PHASE: begin
                    s_nxt.up_allow = pwdata[F_UP_ALLOW];
                    s_nxt.dn_allow = pwdata[F_DN_ALLOW];
                    s_nxt.push_hi  = pwdata[F_PUSH_HI];
                    s_nxt.push_lo  = pwdata[F_PUSH_LO];
                end
                IDX_PIN: begin
                    s_nxt.osel  = pwdata[F_OSEL_LO +: 5];
                    s_nxt.share = pwdata[F_SHARE];
                end
                default: ;
            endcase
        end
        // Read data captured in setup
        if (setup) begin
            s_nxt.prdata = 32'h0000_0000;
            if (!pwrite && mapped) begin
                unique case (idx)
                    IDX_RDIV:  s_nxt.prdata[13:0] = s_r.rdiv;
                    IDX_NINT:  s_nxt.prdata[18:0] = s_r.nint;
                    IDX_NFRAC: s_nxt.prdata[23:0] = s_r.nfrac;
                    IDX_MODE:  s_nxt.prdata[F_FRAC_EN] = s_r.frac_en;
                    IDX_LOCK: begin
                        s_nxt.prdata[F_TGT_LO +: 3]  = s_r.tgt;
                        s_nxt.prdata[F_LD_EN]        = s_r.ld_en;
                        s_nxt.prdata[F_WIN_SEL]      = s_r.win_sel;
                        s_nxt.prdata[F_TDIV_LO +: 3] = s_r.tdiv;
                        s_nxt.prdata[F_TSPD_LO +: 2] = s_r.tspd;
                    end
                    IDX_PHASE: begin
                        s_nxt.prdata[F_UP_ALLOW] = s_r.up_allow;
                        s_nxt.prdata[F_DN_ALLOW] = s_r.dn_allow;
                        s_nxt.prdata[F_PUSH_HI]  = s_r.push_hi;
                        s_nxt.prdata[F_PUSH_LO]  = s_r.push_lo;
                    end
                    IDX_PIN: begin
                        s_nxt.prdata[F_OSEL_LO +: 5] = s_r.osel;
                        s_nxt.prdata[F_SHARE]        = s_r.share;
                    end
                    IDX_STATUS: s_nxt.prdata[F_LOCK] = s_r.lock;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r          <= '0;
            s_r.rdiv     <= RDIV_RST;
            s_r.nint     <= NINT_RST;
            s_r.up_allow <= 1'b1;
            s_r.dn_allow <= 1'b1;
            s_r.osel     <= OSEL_LOCK;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign prdata         = s_r.prdata;
    assign pready         = 1'b1;
    assign pslverr        = access && !mapped;
    assign pump_up        = (s_r.cmp_up && s_r.up_allow && !s_r.push_lo) || s_r.push_hi;
    assign pump_down      = (s_r.cmp_dn && s_r.dn_allow && !s_r.push_hi) || s_r.push_lo;
    assign pump_hiz       = !s_r.up_allow && !s_r.dn_allow && !s_r.push_hi && !s_r.push_lo;
    assign ref_div_edge   = s_r.ref_e;
    assign osc_div_edge   = s_r.osc_e;
    assign lock_indicator = s_r.lock;
    assign lock_or_serial_out_pin = (!s_r.share && serial_read_active) ? serial_data :
                                    ((s_r.osel == OSEL_LOCK) && s_r.lock);

    // Checks
    sequence s_open_miss;
        s_r.ld_en && s_r.win_open && !partner && s_r.win_cnt >= wlen;
    endsequence

    property p_up_mask;
        @(posedge clk_sys) disable iff (sys_rst) !s_r.up_allow && !s_r.push_hi |-> !pump_up;
    endproperty
    a_up_mask: assert property (p_up_mask) else $error("up pulse while masked");

    property p_dn_mask;
        @(posedge clk_sys) disable iff (sys_rst) !s_r.dn_allow && !s_r.push_lo |-> !pump_down;
    endproperty
    a_dn_mask: assert property (p_dn_mask) else $error("down pulse while masked");

    property p_hiz;
        @(posedge clk_sys) disable iff (sys_rst) pump_hiz |-> !pump_up && !pump_down;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pump driven while high impedance");

    property p_push;
        @(posedge clk_sys) disable iff (sys_rst) s_r.push_hi |-> pump_up && !pump_down;
    endproperty
    a_push: assert property (p_push) else $error("push high not forcing up");

    property p_disabled;
        @(posedge clk_sys) disable iff (sys_rst) !s_r.ld_en |=> !lock_indicator && s_r.hits == 12'h000;
    endproperty
    a_disabled: assert property (p_disabled) else $error("lock state kept while disabled");

    property p_miss_drop;
        @(posedge clk_sys) disable iff (sys_rst) s_open_miss |=> !lock_indicator && s_r.hits == 12'h000;
    endproperty
    a_miss_drop: assert property (p_miss_drop) else $error("miss did not drop lock");

    property p_lock_rise;
        @(posedge clk_sys) disable iff (sys_rst)
            $rose(lock_indicator) |-> $past(hit) && s_r.hits == hit_target(s_r.tgt);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock rose without full run");

    property p_status_read;
        @(posedge clk_sys) disable iff (sys_rst)
            setup && !pwrite && paddr == {22'h00_0000, IDX_STATUS, 2'b00} |=> prdata[F_LOCK] == $past(s_r.lock);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read lost lock flag");

    property p_pin_lock;
        @(posedge clk_sys) disable iff (sys_rst)
            s_r.osel == OSEL_LOCK && !serial_read_active |-> lock_or_serial_out_pin == lock_indicator;
    endproperty
    a_pin_lock: assert property (p_pin_lock) else $error("pin not showing lock");

    property p_pin_read;
        @(posedge clk_sys) disable iff (sys_rst)
            !s_r.share && serial_read_active |-> lock_or_serial_out_pin == serial_data;
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin not showing serial data");
endmodule

/* rtl/plc_pkg.sv */
// Purpose: Constants for the phase comparator and lock detector block
// Assumes: APB slave, 50 MHz clk_sys, one word per register at index * 4
// Notes: Window lengths are stored in tenths of a ns
package plc_pkg;
    localparam int          CLK_PERIOD_NS = 20;
    // Register indices; byte address is index * 4
    localparam logic [7:0]  IDX_RDIV      = 8'h02;
    localparam logic [7:0]  IDX_NINT      = 8'h03;
    localparam logic [7:0]  IDX_NFRAC     = 8'h04;
    localparam logic [7:0]  IDX_MODE      = 8'h06;
    localparam logic [7:0]  IDX_LOCK      = 8'h07;
    localparam logic [7:0]  IDX_PHASE     = 8'h0B;
    localparam logic [7:0]  IDX_PIN       = 8'h0F;
    localparam logic [7:0]  IDX_STATUS    = 8'h12;
    // Field positions
    localparam int          F_FRAC_EN     = 11;
    localparam int          F_TGT_LO      = 0;
    localparam int          F_LD_EN       = 3;
    localparam int          F_WIN_SEL     = 6;
    localparam int          F_TDIV_LO     = 7;
    localparam int          F_TSPD_LO     = 10;
    localparam int          F_UP_ALLOW    = 5;
    localparam int          F_DN_ALLOW    = 6;
    localparam int          F_PUSH_HI     = 9;
    localparam int          F_PUSH_LO     = 10;
    localparam int          F_OSEL_LO     = 0;
    localparam int          F_SHARE       = 6;
    localparam int          F_LOCK        = 1;
    // Divider limits and reset values, lock pin select code, lock hit count base
    localparam logic [13:0] RDIV_RST      = 14'h0001;
    localparam logic [18:0] NINT_MIN      = 19'h0_0010;
    localparam logic [18:0] NFRAC_MIN     = 19'h0_0014;
    localparam logic [18:0] NFRAC_MAX     = 19'h7_FFFB;
    localparam logic [18:0] NINT_RST      = 19'h0_0010;
    localparam logic [4:0]  OSEL_LOCK     = 5'h01;
    localparam logic [11:0] HIT_BASE      = 12'h010;
    // Window lengths, tenths of ns
    localparam int          ANALOG_WIN_NS10 = 100;
    localparam logic [15:0] WIN_NS10 [32] = '{
        16'd65,  16'd80,  16'd110, 16'd170, 16'd290, 16'd530, 16'd1000, 16'd1950,
        16'd70,  16'd89,  16'd128, 16'd210, 16'd360, 16'd680, 16'd1300, 16'd2550,
        16'd17,  16'd92,  16'd133, 16'd220, 16'd380, 16'd720, 16'd1380, 16'd2720,
        16'd76,  16'd102, 16'd154, 16'd260, 16'd470, 16'd880, 16'd1720, 16'd3380};
endpackage

/* verif/plc_src_model.sv */
// Purpose: Reference and oscillator sources for the comparator inputs
// Assumes: Square waves, half period in clk_sys cycles
// Notes: Each wave shifted by its own delay; both idle low when disabled
module plc_src_model (
    // Clock
    input  wire logic       clk_sys,
    // Controls
    input  wire logic       en,
    input  wire logic [7:0] half,
    input  wire logic [7:0] ref_dly,
    input  wire logic [7:0] osc_dly,
    // Waves
    output logic            ref_in,
    output logic            osc_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int t = 0;
    function automatic logic wave(input int tt, input int d, input int h);
        return (tt >= d) && (((tt - d) / h) % 2 == 1);
    endfunction
    initial begin
        ref_in = 1'b0;
        osc_in = 1'b0;
    end
    // Delay puts oscillator edge after reference when asked
    // Offsets stay inside one compare period
    // Compare rate far below 50 MHz for the fixed window
    always @(posedge clk_sys) begin
        t      <= en ? t + 1 : 0;
        ref_in <= en && wave(t, ref_dly, half);
        osc_in <= en && wave(t, osc_dly, half);
    end
endmodule

/* verif/plc_core_tb.sv */
// Purpose: Self-checking bench for the comparator and lock detector
// Assumes: APB with queued expectations, monitor compares on access
// Notes: Window 338 ns resolves to 16 cycles, compare period 128 cycles
module plc_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import plc_pkg::*;
    logic        clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic        pready, pslverr, ref_in, osc_in, pump_up, pump_down, pump_hiz;
    logic        serial_read_active = 0, serial_data = 0, lock_or_serial_out_pin;
    logic        ref_div_edge, osc_div_edge, lock_indicator, src_en = 0;
    logic [7:0]  ref_dly = 0, osc_dly = 0;
    logic [32:0] expq[$], cur_exp, v;
    logic [10:0] pv [6] = '{11'h060, 11'h000, 11'h200, 11'h400, 11'h020, 11'h040};
    logic [2:0]  pe [6] = '{3'b000, 3'b001, 3'b100, 3'b010, 3'b000, 3'b000};
    logic [2:0]  pm [6] = '{3'b001, 3'b111, 3'b111, 3'b111, 3'b011, 3'b101};
    int          errors = 0, cmp_count = 0, seed = 98365, n, rp, op;
    always #10 clk_sys = ~clk_sys;
    plc_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_in(ref_in), .osc_in(osc_in), .pump_up(pump_up), .pump_down(pump_down), .pump_hiz(pump_hiz),
        .serial_read_active(serial_read_active), .serial_data(serial_data),
        .lock_or_serial_out_pin(lock_or_serial_out_pin), .ref_div_edge(ref_div_edge),
        .osc_div_edge(osc_div_edge), .lock_indicator(lock_indicator));
    plc_src_model src (.clk_sys(clk_sys), .en(src_en), .half(8'd4), .ref_dly(ref_dly), .osc_dly(osc_dly),
        .ref_in(ref_in), .osc_in(osc_in));
    task print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [2:0] got, input logic [2:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    function automatic logic [31:0] ad(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        expq.push_back(e);
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] i, input logic [31:0] d);
        apb(1'b1, ad(i), d, 33'h0);
    endtask
    task rd(input logic [7:0] i, input logic [32:0] e);
        apb(1'b0, ad(i), 32'h0, e);
    endtask
    task do_reset();
        src_en  <= 1'b0;
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask
    task run_lock(input logic [7:0] rdl, input logic [7:0] odl, input logic [31:0] lr, input logic exp);
        do_reset();
        ref_dly <= rdl;
        osc_dly <= odl;
        wr(IDX_RDIV, 32'd16);
        wr(IDX_LOCK, lr);
        src_en <= 1'b1;
        n = 0;
        while (lock_indicator !== 1'b1 && n < 2600) begin
            @(posedge clk_sys);
            n++;
        end
        chk(lock_indicator, exp, "lock state after run");
        if (exp)
            chk(n > 1900, 1, "lock before full run");
        $display("test lock run %0d %0d done", rdl, odl);
    endtask
    // Access monitor: oldest note per completed transfer
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            cur_exp = expq.pop_front();
            cmp_count++;
            if (pslverr !== cur_exp[32] || (!pwrite && prdata !== cur_exp[31:0])) begin
                errors++;
                $display("CHECK FAILED at %0t: apb %h got %h exp %h", $time, paddr, prdata, cur_exp);
            end
        end
    end
    initial begin
        #(60000 * 20);
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        do_reset();
        rd(IDX_RDIV, 33'h1);
        rd(IDX_NINT, 33'h10);
        rd(IDX_PHASE, 33'h60);
        rd(IDX_PIN, 33'h1);
        rd(IDX_LOCK, 33'h0);
        rd(IDX_STATUS, 33'h0);
        apb(1'b0, 32'h14, 32'h0, 33'h1_0000_0000);
        apb(1'b1, 32'h14, 32'hFFFF, 33'h1_0000_0000);
        apb(1'b0, 32'h09, 32'h0, 33'h1_0000_0000);
        for (int i = 0; i < 4; i++) begin
            v = 33'($unsigned($random(seed)));
            wr(IDX_RDIV, v[31:0]);
            rd(IDX_RDIV, {1'b0, v[31:0] & 32'h3FFF});
            wr(IDX_NINT, v[31:0]);
            rd(IDX_NINT, {1'b0, v[31:0] & 32'h7FFFF});
        end
        $display("test registers done");
        do_reset();
        ref_dly <= 8'd0;
        osc_dly <= 8'd0;
        wr(IDX_RDIV, 32'd3);
        wr(IDX_NINT, 32'd17);
        src_en <= 1'b1;
        rp = 0;
        op = 0;
        repeat (400) begin
            @(posedge clk_sys);
            rp += (ref_div_edge === 1'b1);
            op += (osc_div_edge === 1'b1);
        end
        chk(rp == 16, 1, "reference divide by 3");
        chk(op == 2, 1, "feedback divide by 17");
        $display("test dividers done");
        wr(IDX_RDIV, 32'd1);
        wr(IDX_NINT, 32'd16);
        osc_dly <= 8'd40;
        for (int i = 0; i < 6; i++) begin
            wr(IDX_PHASE, {21'h0, pv[i]});
            rd(IDX_PHASE, {22'h0, pv[i]});
            repeat (64) begin
                @(negedge clk_sys);
                chk({pump_up, pump_down, pump_hiz} & pm[i], pe[i], "pump masks");
            end
        end
        $display("test pump masks done");
        run_lock(8'd0, 8'd3, 32'h0000_0FC8, 1'b1);
        rd(IDX_STATUS, 33'h2);
        @(negedge clk_sys);
        chk(lock_or_serial_out_pin, 1'b1, "pin shows lock");
        @(posedge clk_sys);
        serial_data        <= 1'($random(seed));
        serial_read_active <= 1'b1;
        @(negedge clk_sys);
        chk(lock_or_serial_out_pin, serial_data, "pin shows serial data");
        @(posedge clk_sys);
        serial_read_active <= 1'b0;
        @(negedge clk_sys);
        chk(lock_or_serial_out_pin, 1'b1, "pin back to lock");
        // Feedback ratio 17 drifts the oscillator edge out of the window
        wr(IDX_NINT, 32'd17);
        n = 0;
        while (lock_indicator !== 1'b0 && n < 800) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (512) @(posedge clk_sys);
        chk(lock_indicator, 1'b0, "lock held after miss");
        $display("test lock loss done");
        run_lock(8'd3, 8'd0, 32'h0000_0FC8, 1'b1);
        wr(IDX_LOCK, 32'h0000_0FC0);
        repeat (2) @(posedge clk_sys);
        chk(lock_indicator, 1'b0, "lock off when disabled");
        repeat (512) @(posedge clk_sys);
        chk(lock_indicator, 1'b0, "lock stays off disabled");
        rd(IDX_STATUS, 33'h0);
        run_lock(8'd0, 8'd3, 32'h0000_0008, 1'b0);
        run_lock(8'd0, 8'd3, 32'h0000_0048, 1'b0);
        print_verdict();
    end
endmodule
